// *** rtl/dma_ctrl_pkg.sv ***
// Purpose: shared constants and types of the dual buffer serial dma control
// Assumes: 16-bit register port, 13-bit buffer byte addresses
// Notes: register offsets are byte addresses on the plain register port
package dma_ctrl_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BUF_AW = 13;
    localparam int IRQ_W = 6;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] DMA_STATUS_OFS = 16'h4416;
    localparam logic [15:0] DMA_CONTROL_OFS = 16'h4418;
    localparam logic [15:0] IRQ_STATUS_OFS = 16'h441A;
    localparam logic [15:0] IRQ_CLEAR_OFS = 16'h441C;
    localparam logic [15:0] IRQ_ENABLE_OFS = 16'h441E;

    ////////////////////////////////////////////////////////////////////////////
    // dma_control fields
    localparam int CTL_RX_LOAD_A = 0;
    localparam int CTL_RX_LOAD_B = 1;
    localparam int CTL_TX_LOAD_A = 2;
    localparam int CTL_TX_LOAD_B = 3;
    localparam int CTL_RX_RST = 4;
    localparam int CTL_TX_RST = 5;

    // dma_status fields
    localparam int STS_RX_ACT_A = 0;
    localparam int STS_TX_ACT_A = 2;
    localparam int STS_OVF_A = 4;

    // interrupt status, clear and enable fields
    localparam int IRQ_RX_DONE_A = 0;
    localparam int IRQ_TX_DONE_A = 2;
    localparam int IRQ_OVF_A = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RD_DATA_RST = 16'h0000;
    localparam logic [5:0] IRQ_RST = 6'h00;
    localparam logic [12:0] PTR_RST = 13'h0000;

    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_RUN = 1'b1
    } chan_state_t;

endpackage

// *** rtl/dma_channel.sv ***
// Purpose: one direction of the a/b buffer dma engine
// Assumes: partner pulses ack once per byte while req is high
// Notes: end address is inclusive; buffer a is served first after reset
`timescale 1ns/1ps

module dma_channel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic dma_rst,
    input wire logic load_a,
    input wire logic load_b,
    input wire logic [12:0] beg_a,
    input wire logic [12:0] end_a,
    input wire logic [12:0] beg_b,
    input wire logic [12:0] end_b,
    // byte transfer
    input wire logic ack,
    output logic req,
    output logic [12:0] addr,
    // state
    output logic [1:0] load_bits,
    output logic [1:0] active,
    output logic next_b,
    output logic [1:0] done
);

    typedef struct packed {
        dma_ctrl_pkg::chan_state_t state;
        logic req;
        logic sel;
        logic next_b;
        logic [1:0] lod;
        logic [1:0] done;
        logic [12:0] ptr;
        logic [12:0] beg_a;
        logic [12:0] end_a;
        logic [12:0] beg_b;
        logic [12:0] end_b;
    } chan_t;

    chan_t st_reg;
    chan_t st_next;
    logic pick;

    always_comb begin
        st_next = st_reg;
        st_next.done = 2'h0;
        pick = st_reg.lod[st_reg.next_b] ? st_reg.next_b : !st_reg.next_b;
        if (dma_rst) begin
            // reset drops pending loads too
            st_next.state = dma_ctrl_pkg::CH_IDLE;
            st_next.req = 1'b0;
            st_next.lod = 2'h0;
            st_next.sel = 1'b0;
            st_next.next_b = 1'b0;
            st_next.ptr = dma_ctrl_pkg::PTR_RST;
        end else begin
            // a reload of a busy buffer would corrupt it, so it is ignored
            if (load_a && !st_reg.lod[0]) begin
                st_next.lod[0] = 1'b1;
                st_next.beg_a = beg_a;
                st_next.end_a = end_a;
            end
            if (load_b && !st_reg.lod[1]) begin
                st_next.lod[1] = 1'b1;
                st_next.beg_b = beg_b;
                st_next.end_b = end_b;
            end
            case (st_reg.state)
                dma_ctrl_pkg::CH_IDLE: begin
                    if (|st_reg.lod) begin
                        st_next.state = dma_ctrl_pkg::CH_RUN;
                        st_next.req = 1'b1;
                        st_next.sel = pick;
                        st_next.ptr = pick ? st_reg.beg_b : st_reg.beg_a;
                    end
                end
                dma_ctrl_pkg::CH_RUN: begin
                    if (ack) begin
                        if (st_reg.ptr == (st_reg.sel ? st_reg.end_b : st_reg.end_a)) begin
                            st_next.lod[st_reg.sel] = 1'b0;
                            st_next.done[st_reg.sel] = 1'b1;
                            st_next.next_b = !st_reg.sel;
                            st_next.state = dma_ctrl_pkg::CH_IDLE;
                            st_next.req = 1'b0;
                        end else begin
                            st_next.ptr = st_reg.ptr + 13'h0001;
                        end
                    end
                end
                default: begin
                    st_next.state = dma_ctrl_pkg::CH_IDLE;
                    st_next.req = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign req = st_reg.req;
    assign addr = st_reg.ptr;
    assign load_bits = st_reg.lod;
    assign active = {st_reg.req & st_reg.sel, st_reg.req & !st_reg.sel};
    assign next_b = st_reg.next_b;
    assign done = st_reg.done;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_last_byte;
        st_reg.req && ack && !dma_rst
            && st_reg.ptr == (st_reg.sel ? st_reg.end_b : st_reg.end_a);
    endsequence

    property p_done_clears;
        @(posedge ref_clk) disable iff (rst)
        s_last_byte |=> !st_reg.lod[$past(st_reg.sel)] && !st_reg.req
            && st_reg.done[$past(st_reg.sel)];
    endproperty

    chk_done_clears: assert property (p_done_clears)
        else $error("load bit not cleared after last byte");

endmodule

// *** rtl/serial_dual_buffer_dma_ctrl.sv ***
// Purpose: control and status registers of the dual buffer serial dma
// Assumes: one clock, buffer addresses come from the address registers outside
// Notes: read data is valid only in the cycle after the read strobe
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - writing one to control bit 5 resets transmit dma; bit self-clears.
// - writing one to control bit 4 resets receive dma; bit self-clears.
// - control bit 3 latches transmit buffer b addresses and starts it.
// - control bit 2 latches transmit buffer a addresses and starts it.
// - control bit 1 latches receive buffer b addresses and starts it.
// - control bit 0 latches receive buffer a addresses and starts it.
// - hardware clears each load bit when its buffer transfer completes.
// - writing zero to a load bit changes nothing.
// - a load bit reads one while its buffer is active or pending.
// - a load bit reads zero once its buffer is complete or idle.
module serial_dual_buffer_dma_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // buffer address configuration
    input wire logic [12:0] rx_beg_a,
    input wire logic [12:0] rx_end_a,
    input wire logic [12:0] rx_beg_b,
    input wire logic [12:0] rx_end_b,
    input wire logic [12:0] tx_beg_a,
    input wire logic [12:0] tx_end_a,
    input wire logic [12:0] tx_beg_b,
    input wire logic [12:0] tx_end_b,
    // transmit byte transfer
    output logic tx_req,
    output logic [12:0] tx_addr,
    input wire logic tx_ack,
    // receive byte transfer
    output logic rx_req,
    output logic [12:0] rx_addr,
    input wire logic rx_ack,
    input wire logic rx_fifo_overflow,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic [15:0] rd_data;
        logic [1:0] ovf;
        logic [5:0] irq_sts;
        logic [5:0] irq_en;
        logic irq;
    } regs_t;

    regs_t st_reg;
    regs_t st_next;

    logic wr_ctl;
    logic tx_dma_reset;
    logic rx_dma_reset;
    logic tx_load_buf_a;
    logic tx_load_buf_b;
    logic rx_load_buf_a;
    logic rx_load_buf_b;
    logic [1:0] tx_lod;
    logic [1:0] rx_lod;
    logic [1:0] tx_act;
    logic [1:0] rx_act;
    logic [1:0] tx_done;
    logic [1:0] rx_done;
    logic tx_next_b;
    logic rx_next_b;
    logic [1:0] ovf_set;
    logic [5:0] irq_ev;
    logic [15:0] ctl_view;
    logic [15:0] sts_view;

    ////////////////////////////////////////////////////////////////////////////
    // control write decode
    assign wr_ctl = wr_en && addr == dma_ctrl_pkg::DMA_CONTROL_OFS;
    // reset bits are strobes, never stored, so they always read zero
    assign tx_dma_reset = wr_ctl && wr_data[dma_ctrl_pkg::CTL_TX_RST];
    assign rx_dma_reset = wr_ctl && wr_data[dma_ctrl_pkg::CTL_RX_RST];
    // only ones act; zeros leave load bits alone
    assign tx_load_buf_b = wr_ctl && wr_data[dma_ctrl_pkg::CTL_TX_LOAD_B];
    assign tx_load_buf_a = wr_ctl && wr_data[dma_ctrl_pkg::CTL_TX_LOAD_A];
    assign rx_load_buf_b = wr_ctl && wr_data[dma_ctrl_pkg::CTL_RX_LOAD_B];
    assign rx_load_buf_a = wr_ctl && wr_data[dma_ctrl_pkg::CTL_RX_LOAD_A];

    ////////////////////////////////////////////////////////////////////////////
    // engines
    dma_channel tx_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .dma_rst(tx_dma_reset),
        .load_a(tx_load_buf_a),
        .load_b(tx_load_buf_b),
        .beg_a(tx_beg_a),
        .end_a(tx_end_a),
        .beg_b(tx_beg_b),
        .end_b(tx_end_b),
        .ack(tx_ack),
        .req(tx_req),
        .addr(tx_addr),
        .load_bits(tx_lod),
        .active(tx_act),
        .next_b(tx_next_b),
        .done(tx_done)
    );

    dma_channel rx_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .dma_rst(rx_dma_reset),
        .load_a(rx_load_buf_a),
        .load_b(rx_load_buf_b),
        .beg_a(rx_beg_a),
        .end_a(rx_end_a),
        .beg_b(rx_beg_b),
        .end_b(rx_end_b),
        .ack(rx_ack),
        .req(rx_req),
        .addr(rx_addr),
        .load_bits(rx_lod),
        .active(rx_act),
        .next_b(rx_next_b),
        .done(rx_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // overrun: only counts while neither receive buffer can take bytes
    assign ovf_set[0] = rx_fifo_overflow && rx_lod == 2'h0 && !rx_next_b;
    assign ovf_set[1] = rx_fifo_overflow && rx_lod == 2'h0 && rx_next_b;

    assign irq_ev = {ovf_set, tx_done, rx_done};

    // load bits mirror the engine: one while active or pending
    assign ctl_view = {12'h000, tx_lod, rx_lod};
    // active flags straight from the engines
    assign sts_view = {10'h000, st_reg.ovf, tx_act, rx_act};

    always_comb begin
        st_next = st_reg;
        // reloading a buffer clears its overrun; a new overrun wins
        if (rx_load_buf_a) begin
            st_next.ovf[0] = 1'b0;
        end
        if (rx_load_buf_b) begin
            st_next.ovf[1] = 1'b0;
        end
        if (rx_dma_reset) begin
            st_next.ovf = 2'h0;
        end
        st_next.ovf = st_next.ovf | ovf_set;
        if (wr_en && addr == dma_ctrl_pkg::IRQ_ENABLE_OFS) begin
            st_next.irq_en = wr_data[5:0];
        end
        if (wr_en && addr == dma_ctrl_pkg::IRQ_CLEAR_OFS) begin
            st_next.irq_sts = st_reg.irq_sts & ~wr_data[5:0];
        end
        st_next.irq_sts = st_next.irq_sts | irq_ev;
        st_next.irq = |(st_next.irq_sts & st_next.irq_en);
        st_next.rd_data = dma_ctrl_pkg::RD_DATA_RST;
        if (rd_en) begin
            case (addr)
                dma_ctrl_pkg::DMA_STATUS_OFS: st_next.rd_data = sts_view;
                dma_ctrl_pkg::DMA_CONTROL_OFS: st_next.rd_data = ctl_view;
                dma_ctrl_pkg::IRQ_STATUS_OFS: st_next.rd_data = {10'h000, st_reg.irq_sts};
                dma_ctrl_pkg::IRQ_ENABLE_OFS: st_next.rd_data = {10'h000, st_reg.irq_en};
                default: st_next.rd_data = dma_ctrl_pkg::RD_DATA_RST;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg.rd_data <= dma_ctrl_pkg::RD_DATA_RST;
            st_reg.ovf <= 2'h0;
            st_reg.irq_sts <= dma_ctrl_pkg::IRQ_RST;
            st_reg.irq_en <= dma_ctrl_pkg::IRQ_RST;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rd_data;
    assign irq = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_tx_reset_clears: assert property (
        tx_dma_reset |=> tx_lod == 2'h0 && !tx_req && tx_act == 2'h0)
        else $error("transmit dma reset left state behind");

    chk_rx_reset_clears: assert property (
        rx_dma_reset |=> rx_lod == 2'h0 && !rx_req
            && (st_reg.ovf == 2'h0 || $past(rx_fifo_overflow)))
        else $error("receive dma reset left state behind");

    chk_reset_reads_zero: assert property (
        rd_en && addr == dma_ctrl_pkg::DMA_CONTROL_OFS |=> rd_data[5:4] == 2'h0)
        else $error("reset bits read back as one");

    chk_txb_start: assert property (
        tx_load_buf_b && !tx_dma_reset && !tx_lod[1] |=> tx_lod[1] ##[1:2] tx_req)
        else $error("transmit buffer b did not start");

    chk_txa_start: assert property (
        tx_load_buf_a && !tx_dma_reset && !tx_lod[0] |=> tx_lod[0] ##[1:2] tx_req)
        else $error("transmit buffer a did not start");

    sequence s_rxb_load;
        rx_load_buf_b && !rx_dma_reset && !rx_lod[1] && !rx_req;
    endsequence

    sequence s_rxb_run;
        rx_lod[1] ##1 rx_req && rx_act != 2'h0;
    endsequence

    chk_rxb_start: assert property (s_rxb_load |=> s_rxb_run)
        else $error("receive buffer b did not start");

    chk_rxa_start: assert property (
        rx_load_buf_a && !rx_dma_reset && !rx_lod[0] && rx_lod[1] == 1'b0 && !rx_req
            |=> rx_lod[0] ##1 rx_act[0] && rx_addr == $past(rx_beg_a, 2))
        else $error("receive buffer a did not start at its begin address");

    chk_zero_no_effect: assert property (
        wr_ctl && wr_data[5:0] == 6'h00 && !tx_ack && !rx_ack
            |=> $stable(tx_lod) && $stable(rx_lod))
        else $error("writing zero changed a load bit");

    chk_load_readback: assert property (
        rd_en && addr == dma_ctrl_pkg::DMA_CONTROL_OFS
            |=> rd_data == {12'h000, $past(tx_lod), $past(rx_lod)})
        else $error("load bits read back wrong");

    chk_active_pending: assert property (
        (tx_act != 2'h0) |-> (tx_lod & tx_act) == tx_act)
        else $error("active buffer not shown as loaded");

    chk_status_active: assert property (
        rd_en && addr == dma_ctrl_pkg::DMA_STATUS_OFS
            |=> rd_data[3:0] == {$past(tx_act), $past(rx_act)})
        else $error("active flags read back wrong");

    chk_overrun_flag: assert property (
        rx_fifo_overflow && rx_lod == 2'h0 |=> st_reg.ovf[$past(rx_next_b)])
        else $error("receive overrun not flagged on next buffer");

    chk_irq_level: assert property (
        st_reg.irq_sts[dma_ctrl_pkg::IRQ_OVF_A] && st_reg.irq_en[dma_ctrl_pkg::IRQ_OVF_A]
            |-> irq)
        else $error("enabled status bit without interrupt");

    chk_rd_idle_zero: assert property (
        !rd_en |=> rd_data == dma_ctrl_pkg::RD_DATA_RST)
        else $error("read data not zero outside a read");

    chk_sts_upper_zero: assert property (
        rd_en && addr == dma_ctrl_pkg::DMA_STATUS_OFS |=> rd_data[15:6] == 10'h000)
        else $error("unused status bits read as one");

    chk_overrun_readback: assert property (
        rd_en && addr == dma_ctrl_pkg::DMA_STATUS_OFS |=> rd_data[5:4] == $past(st_reg.ovf))
        else $error("overrun flags read back wrong");

    chk_rx_active_loaded: assert property (
        (rx_act & ~rx_lod) == 2'h0)
        else $error("active receive buffer not shown as loaded");

    chk_act_onehot: assert property (
        $onehot0(tx_act) && $onehot0(rx_act))
        else $error("two buffers of one engine active at once");

    chk_act_follows_req: assert property (
        (tx_act != 2'h0) == tx_req && (rx_act != 2'h0) == rx_req)
        else $error("active flags disagree with engine request");

    chk_tx_done_clears: assert property (
        tx_done != 2'h0 |-> (tx_done & tx_lod) == 2'h0)
        else $error("transmit load bit still set after completion");

    chk_rx_done_clears: assert property (
        rx_done != 2'h0 |-> (rx_done & rx_lod) == 2'h0)
        else $error("receive load bit still set after completion");

    chk_txa_no_drop: assert property (
        $fell(tx_lod[0]) |-> tx_done[0] || $past(tx_dma_reset))
        else $error("transmit a load bit dropped without completion");

    chk_rxb_no_drop: assert property (
        $fell(rx_lod[1]) |-> rx_done[1] || $past(rx_dma_reset))
        else $error("receive b load bit dropped without completion");

    chk_rxa_rise_load: assert property (
        $rose(rx_lod[0]) |-> $past(rx_load_buf_a))
        else $error("receive a load bit set without a load write");

    chk_txb_rise_load: assert property (
        $rose(tx_lod[1]) |-> $past(tx_load_buf_b))
        else $error("transmit b load bit set without a load write");

    chk_irq_raise: assert property (
        (irq_ev & st_reg.irq_en) != 6'h00 && !(wr_en && addr == dma_ctrl_pkg::IRQ_ENABLE_OFS)
            |=> irq)
        else $error("enabled event did not raise the interrupt");

    chk_irq_sticky: assert property (
        irq_ev != 6'h00 |=> (st_reg.irq_sts & $past(irq_ev)) == $past(irq_ev))
        else $error("event lost against a clear");

    chk_ovf_sticky: assert property (
        st_reg.ovf[0] && !rx_load_buf_a && !rx_dma_reset |=> st_reg.ovf[0])
        else $error("overrun flag of buffer a dropped on its own");

    chk_ovf_cause: assert property (
        $rose(st_reg.ovf[0]) |-> $past(rx_fifo_overflow && rx_lod == 2'h0 && !rx_next_b))
        else $error("overrun flag of buffer a set without a cause");

    chk_tx_addr_step: assert property (
        tx_req && tx_ack && !tx_dma_reset |=> !tx_req || tx_addr == $past(tx_addr) + 13'h0001)
        else $error("transmit address did not step by one byte");

    chk_rx_addr_step: assert property (
        rx_req && rx_ack && !rx_dma_reset |=> !rx_req || rx_addr == $past(rx_addr) + 13'h0001)
        else $error("receive address did not step by one byte");

    chk_tx_addr_hold: assert property (
        tx_req && !tx_ack && !tx_dma_reset |=> tx_addr == $past(tx_addr))
        else $error("transmit address moved without a byte");

    chk_rx_alternate: assert property (
        rx_done != 2'h0 |-> rx_next_b == rx_done[0])
        else $error("receive engine did not alternate buffers");

    chk_irq_en_write: assert property (
        wr_en && addr == dma_ctrl_pkg::IRQ_ENABLE_OFS |=> st_reg.irq_en == $past(wr_data[5:0]))
        else $error("interrupt enable write not taken");

endmodule

// *** dv/fifo_port_model.sv ***
// Purpose: byte side of the serial fifo and memory bus, one direction
// Assumes: one ack pulse moves one byte while req is high
// Notes: slow mode acks every fourth cycle to keep a buffer pending
`timescale 1ns/1ps

module fifo_port_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // byte handshake
    input wire logic req,
    input wire logic slow,
    output logic ack
);
    logic [1:0] cnt_reg;

    // ack is registered, so a late one may land after req falls; the block ignores it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 2'h0;
            ack <= 1'b0;
        end else begin
            cnt_reg <= req ? cnt_reg + 2'h1 : 2'h0;
            ack <= req && (!slow || cnt_reg == 2'h3);
        end
    end
endmodule

// *** dv/serial_dual_buffer_dma_ctrl_tb_top.sv ***
// Purpose: register level test of the dual buffer dma control
// Assumes: two fifo port models answer the byte handshakes
// Notes: buffer index 0 rx a, 1 rx b, 2 tx a, 3 tx b, as the load bits
`timescale 1ns/1ps

module serial_dual_buffer_dma_ctrl_tb_top;
    logic ref_clk;
    logic rst;
    logic [15:0] addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic wr_en;
    logic rd_en;
    logic [12:0] beg [4];
    logic [12:0] fin [4];
    logic tx_req;
    logic [12:0] tx_addr;
    logic tx_ack;
    logic rx_req;
    logic [12:0] rx_addr;
    logic rx_ack;
    logic rx_fifo_overflow;
    logic irq;
    logic slow;
    logic [12:0] q[$];
    logic [15:0] d;
    int fails = 0;
    int samples_checked = 0;

    serial_dual_buffer_dma_ctrl serial_dual_buffer_dma_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .rx_beg_a(beg[0]), .rx_end_a(fin[0]),
        .rx_beg_b(beg[1]), .rx_end_b(fin[1]), .tx_beg_a(beg[2]), .tx_end_a(fin[2]),
        .tx_beg_b(beg[3]), .tx_end_b(fin[3]), .tx_req(tx_req), .tx_addr(tx_addr),
        .tx_ack(tx_ack), .rx_req(rx_req), .rx_addr(rx_addr), .rx_ack(rx_ack),
        .rx_fifo_overflow(rx_fifo_overflow), .irq(irq)
    );
    fifo_port_model rx_fifo_port_model_inst (
        .ref_clk(ref_clk), .rst(rst), .req(rx_req), .slow(slow), .ack(rx_ack)
    );
    fifo_port_model tx_fifo_port_model_inst (
        .ref_clk(ref_clk), .rst(rst), .req(tx_req), .slow(slow), .ack(tx_ack)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // record every byte address that the engine hands over
    always @(posedge ref_clk) begin
        if (rx_req === 1'b1 && rx_ack === 1'b1) q.push_back(rx_addr);
        if (tx_req === 1'b1 && tx_ack === 1'b1) q.push_back(tx_addr);
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 200; n++) begin
            rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
            if (d[3:0] === 4'h0) break;
        end
    endtask

    task automatic pulse_overflow();
        @(posedge ref_clk);
        rx_fifo_overflow <= 1'b1;
        @(posedge ref_clk);
        rx_fifo_overflow <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        fails++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        addr = 16'h0000;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        rx_fifo_overflow = 1'b0;
        slow = 1'b1;
        beg = '{13'h0005, 13'h0010, 13'h1FFE, 13'h0000};
        fin = '{13'h0006, 13'h0012, 13'h1FFF, 13'h0000};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("status_reset", d, 16'h0000);
        rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
        chk("control_reset", d, 16'h0000);
        rd(16'h4420, d);
        chk("unmapped", d, 16'h0000);
        wr(dma_ctrl_pkg::DMA_STATUS_OFS, 16'h003F);
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("status_ro", d, 16'h0000);
        // each load bit: pending view, active flag, self clear, addresses moved
        for (int i = 0; i < 4; i++) begin
            q.delete();
            wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0001 << i);
            rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
            chk("load_busy", d, 16'h0001 << i);
            rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
            chk("active_flag", d, 16'h0001 << i);
            wait_idle();
            chk("load_done", d, 16'h0000);
            d = 16'(fin[i] - beg[i] + 13'h1);
            chk("byte_count", 16'(q.size()), d);
            chk("first_addr", {3'h0, q[0]}, {3'h0, beg[i]});
            chk("last_addr", {3'h0, q[$]}, {3'h0, fin[i]});
        end
        // both tx buffers queued, a zero write must not disturb them
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h000C);
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0000);
        rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
        chk("zero_write", d, 16'h000C);
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("a_active_b_pending", d, 16'h0004);
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0020);
        rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
        chk("tx_reset_ctl", d, 16'h0000);
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("tx_reset_sts", d, 16'h0000);
        chk("tx_req_off", {15'h0000, tx_req}, 16'h0000);
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0003);
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0010);
        rd(dma_ctrl_pkg::DMA_CONTROL_OFS, d);
        chk("rx_reset_ctl", d, 16'h0000);
        chk("rx_req_off", {15'h0000, rx_req}, 16'h0000);
        // overrun with nothing loaded lands on the buffer due next
        pulse_overflow();
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("overrun_a", d, 16'h0010);
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0010);
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("overrun_cleared", d, 16'h0000);
        // interrupt: raise from rx done, mask, unmask overrun, clear
        wr(dma_ctrl_pkg::IRQ_CLEAR_OFS, 16'h003F);
        wr(dma_ctrl_pkg::IRQ_ENABLE_OFS, 16'h0001);
        slow <= 1'b0;
        wr(dma_ctrl_pkg::DMA_CONTROL_OFS, 16'h0001);
        wait_idle();
        pulse_overflow();
        rd(dma_ctrl_pkg::DMA_STATUS_OFS, d);
        chk("overrun_b", d, 16'h0020);
        chk("irq_on", {15'h0000, irq}, 16'h0001);
        rd(dma_ctrl_pkg::IRQ_STATUS_OFS, d);
        chk("irq_status", d, 16'h0021);
        rd(dma_ctrl_pkg::IRQ_ENABLE_OFS, d);
        chk("irq_enable", d, 16'h0001);
        wr(dma_ctrl_pkg::IRQ_ENABLE_OFS, 16'h0000);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq_masked", {15'h0000, irq}, 16'h0000);
        wr(dma_ctrl_pkg::IRQ_ENABLE_OFS, 16'h0020);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq_overrun", {15'h0000, irq}, 16'h0001);
        wr(dma_ctrl_pkg::IRQ_CLEAR_OFS, 16'h003F);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq_cleared", {15'h0000, irq}, 16'h0000);
        rd(dma_ctrl_pkg::IRQ_STATUS_OFS, d);
        chk("irq_status_clr", d, 16'h0000);
        end_sim();
    end
endmodule
